// ---- logic/atbs_div.sv ----
`timescale 1ns/1ps
`default_nettype none
module atbs_div #(
  parameter int DIV_W = 16
) (
  input  wire logic clk,  // Reference clock.
  input  wire logic rst,  // Synchronous reset.
  atbs_div_if.div   bus   // Divider control and outputs.
);

  logic [DIV_W-1:0] count;
  logic             wrap;

  assign wrap = bus.run && (count >= bus.divisor);

  ////////////////////////////////////////////////////////////////////////////
  // Comparing with >= keeps the divider sane if software lowers the divisor.
  // reference clock count
  always_ff @(posedge clk) begin
    if (rst || !bus.run) begin
      count <= '0;
    end else if (wrap) begin
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !bus.run) begin
      bus.tick  <= 1'b0;
      bus.phase <= 1'b0;
    end else begin
      bus.tick  <= wrap;
      bus.phase <= bus.phase ^ wrap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_tick_run;
    @(posedge clk) disable iff (rst)
    bus.tick |-> $past(bus.run);
  endproperty
  a_tick_run: assert property (p_tick_run) else $error("Divider ticked while stopped.");

endmodule
`default_nettype wire

// ---- logic/atbs_div_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface atbs_div_if #(
  parameter int DIV_W = 16
);
  logic             run;
  logic [DIV_W-1:0] divisor;
  logic             tick;
  logic             phase;

  modport ctl (output run, output divisor, input tick, input phase);
  modport div (input run, input divisor, output tick, output phase);
endinterface
`default_nettype wire

// ---- logic/atbs_pkg.sv ----
// Operation
// - Base sample rate comes from the single 100 MHz reference clock.
// - Other sample rates come from a programmable divider set per time range.
// - Count pre-trigger samples after start, then raise the trigger enable request.
// - Qualified trigger event starts the post-trigger countdown.
// - Post-trigger load value is programmable and sets post-trigger data amount.
// - Countdown reaching zero stops sample clocks and flags completion to the CPU.
// - One stretcher pulse, from trigger to next sample clock edge.
// - Interpolation counter runs during stretching, stops at stretch completion.
// - Interpolation counter covers about 1000 times the trigger-to-sample time.
// - Final interpolation count is stored for placing samples against the trigger.
// - From 250 MHz to 2 GHz the clock feeds the converter multiplying loop.
// - Maximum sample rate is a parameter, 1 GSa/s or 2 GSa/s.
package atbs_pkg;

  localparam int unsigned REF_CLK_HZ     = 100_000_000;
  localparam int unsigned REF_MHZ        = REF_CLK_HZ / 1_000_000;
  localparam int unsigned PLL_MIN_MHZ    = 250;
  localparam int unsigned PLL_MAX_MHZ    = 2000;
  localparam int unsigned STRETCH_FACTOR = 1000;
  localparam int unsigned LOW_RATE_MSPS  = 1000;
  localparam int unsigned FULL_RATE_MSPS = 2000;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned MULT_W = 5;
  localparam int unsigned INT_W  = 3;

  localparam logic [7:0] OFF_CTRL       = 8'h00;
  localparam logic [7:0] OFF_DIVISOR    = 8'h04;
  localparam logic [7:0] OFF_PLL_MULT   = 8'h08;
  localparam logic [7:0] OFF_PRE_LEN    = 8'h0C;
  localparam logic [7:0] OFF_POST_LEN   = 8'h10;
  localparam logic [7:0] OFF_STATUS     = 8'h14;
  localparam logic [7:0] OFF_INT_STATUS = 8'h18;
  localparam logic [7:0] OFF_INT_MASK   = 8'h1C;
  localparam logic [7:0] OFF_INTERP     = 8'h20;
  localparam logic [7:0] OFF_CAPS       = 8'h24;

  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_ABORT_BIT = 1;

  localparam int unsigned ST_RUN_BIT     = 0;
  localparam int unsigned ST_ARMED_BIT   = 1;
  localparam int unsigned ST_POST_BIT    = 2;
  localparam int unsigned ST_DONE_BIT    = 3;
  localparam int unsigned ST_STRETCH_BIT = 4;
  localparam int unsigned ST_IVALID_BIT  = 5;
  localparam int unsigned ST_PLL_BIT     = 6;

  localparam int unsigned INT_DONE_BIT   = 0;
  localparam int unsigned INT_TRIG_BIT   = 1;
  localparam int unsigned INT_INTERP_BIT = 2;

  localparam logic [31:0] DIVISOR_RST  = 32'h0000_0000;
  localparam logic [31:0] PRE_LEN_RST  = 32'h0000_0000;
  localparam logic [31:0] POST_LEN_RST = 32'h0000_0000;
  localparam logic [4:0]  MULT_RST     = 5'h00;
  localparam logic [2:0]  MASK_RST     = 3'h0;

  typedef enum {ST_IDLE, ST_PRE, ST_ARMED, ST_POST, ST_DONE} atbs_state_t;
  typedef enum {IS_IDLE, IS_PULSE, IS_WAIT} atbs_istate_t;

endpackage

// ---- logic/atbs_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module atbs_top #(
  parameter int DIV_W         = 16,
  parameter int CNT_W         = 24,
  parameter int MAX_RATE_MSPS = 2000
) (
  input  wire logic                          clk,                      // 100 MHz reference.
  input  wire logic                          rst,                      // Synchronous reset.
  input  wire logic [atbs_pkg::ADDR_W-1:0]   reg_addr,                 // Register byte address.
  input  wire logic [atbs_pkg::DATA_W-1:0]   reg_wdata,                // Register write data.
  input  wire logic                          reg_wr,                   // Write strobe.
  input  wire logic                          reg_rd,                   // Read strobe.
  output logic      [atbs_pkg::DATA_W-1:0]   reg_rdata,                // Read data, next cycle.
  input  wire logic                          qualified_trigger_event,  // Trigger from multiplexer.
  input  wire logic                          stretch_done,             // Stretcher finished.
  output logic                               trigger_enable_req,       // Ready for trigger.
  output logic                               stretch_pulse,            // Pulse to stretcher.
  output logic                               sample_clk_out,           // Direct sample clock.
  output logic                               pll_ref_clk,              // Clock to converter loop.
  output logic      [atbs_pkg::MULT_W-1:0]   pll_mult_out,             // Loop multiplier.
  output logic                               acq_done,                 // Acquisition complete.
  output logic                               irq                       // Level interrupt.
);

  localparam int INTERP_W = $clog2(atbs_pkg::STRETCH_FACTOR) + DIV_W + 1;
  localparam int MAX_MULT = MAX_RATE_MSPS / atbs_pkg::REF_MHZ;

  if (MAX_RATE_MSPS != atbs_pkg::LOW_RATE_MSPS && MAX_RATE_MSPS != atbs_pkg::FULL_RATE_MSPS) begin : g_bad_rate
    $error("MAX_RATE_MSPS must be 1000 or 2000.");
  end
  if (DIV_W < 2 || DIV_W > 32 || CNT_W < 2 || CNT_W > 32 || INTERP_W > 32) begin : g_bad_width
    $error("Counter widths out of range.");
  end

  ////////////////////////////////////////////////////////////////////////////
  atbs_pkg::atbs_state_t  state;
  atbs_pkg::atbs_istate_t i_state;

  logic [DIV_W-1:0]           divisor;
  logic [atbs_pkg::MULT_W-1:0] pll_mult;
  logic [atbs_pkg::MULT_W-1:0] eff_mult;
  logic [CNT_W-1:0]           pre_len;
  logic [CNT_W-1:0]           post_len;
  logic [CNT_W-1:0]           pre_cnt;
  logic [CNT_W-1:0]           post_cnt;
  logic [INTERP_W-1:0]        icnt;
  logic [INTERP_W-1:0]        icnt_inc;
  logic [INTERP_W-1:0]        interp_result;
  logic                       interp_valid;
  logic [atbs_pkg::INT_W-1:0] int_status;
  logic [atbs_pkg::INT_W-1:0] int_mask;
  logic [atbs_pkg::INT_W-1:0] ev_vec;
  logic [atbs_pkg::INT_W-1:0] w1c;
  logic                       trig_s1, trig_s2, trig_s3;
  logic                       done_s1, done_s2, done_s3;
  logic                       trig_edge;
  logic                       stretch_edge;
  logic                       start_cmd;
  logic                       abort_cmd;
  logic                       ctrl_wr;
  logic                       run;
  logic                       pll_mode;
  logic                       ev_trig;
  logic                       ev_done;
  logic                       ev_interp;

  atbs_div_if #(.DIV_W(DIV_W)) div_bus ();

  atbs_div #(.DIV_W(DIV_W)) u_div (
    .clk (clk),
    .rst (rst),
    .bus (div_bus)
  );

  assign div_bus.run     = run;
  assign div_bus.divisor = divisor;

  ////////////////////////////////////////////////////////////////////////////
  // Pins from the trigger and stretcher are asynchronous to the reference.
  always_ff @(posedge clk) begin
    if (rst) begin
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      trig_s3 <= 1'b0;
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
      done_s3 <= 1'b0;
    end else begin
      trig_s1 <= qualified_trigger_event;
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
      done_s1 <= stretch_done;
      done_s2 <= done_s1;
      done_s3 <= done_s2;
    end
  end

  assign trig_edge    = trig_s2 && !trig_s3;
  assign stretch_edge = done_s2 && !done_s3;

  ////////////////////////////////////////////////////////////////////////////
  assign ctrl_wr   = reg_wr && (reg_addr == atbs_pkg::OFF_CTRL);
  assign start_cmd = ctrl_wr && reg_wdata[atbs_pkg::CTRL_START_BIT];
  assign abort_cmd = ctrl_wr && reg_wdata[atbs_pkg::CTRL_ABORT_BIT] && !start_cmd;

  always_ff @(posedge clk) begin
    if (rst) begin
      divisor  <= DIV_W'(atbs_pkg::DIVISOR_RST);
      pll_mult <= atbs_pkg::MULT_RST;
      pre_len  <= CNT_W'(atbs_pkg::PRE_LEN_RST);
      post_len <= CNT_W'(atbs_pkg::POST_LEN_RST);
      int_mask <= atbs_pkg::MASK_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        atbs_pkg::OFF_DIVISOR:  divisor  <= reg_wdata[DIV_W-1:0];
        atbs_pkg::OFF_PLL_MULT: pll_mult <= reg_wdata[atbs_pkg::MULT_W-1:0];
        atbs_pkg::OFF_PRE_LEN:  pre_len  <= reg_wdata[CNT_W-1:0];
        atbs_pkg::OFF_POST_LEN: post_len <= reg_wdata[CNT_W-1:0];
        atbs_pkg::OFF_INT_MASK: int_mask <= reg_wdata[atbs_pkg::INT_W-1:0];
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Acquisition sequence. Abort and start act from any state.
  always_ff @(posedge clk) begin
    if (rst || abort_cmd) begin
      state <= atbs_pkg::ST_IDLE;
    end else if (start_cmd) begin
      state <= atbs_pkg::ST_PRE;
    end else begin
      unique case (state)
        atbs_pkg::ST_IDLE: begin
        end
        atbs_pkg::ST_PRE: begin
          if (pre_cnt >= pre_len) state <= atbs_pkg::ST_ARMED;
        end
        atbs_pkg::ST_ARMED: begin
          if (trig_edge) state <= atbs_pkg::ST_POST;
        end
        atbs_pkg::ST_POST: begin
          if (post_cnt == '0) state <= atbs_pkg::ST_DONE;
        end
        atbs_pkg::ST_DONE: begin
        end
      endcase
    end
  end

  // trigger accepted only when armed
  // Only start or abort overrides the sequence, so a plain CTRL write must not mask these events.
  assign ev_trig = (state == atbs_pkg::ST_ARMED) && trig_edge && !start_cmd && !abort_cmd;
  assign ev_done = (state == atbs_pkg::ST_POST) && (post_cnt == '0) && !start_cmd && !abort_cmd;
  assign run = (state == atbs_pkg::ST_PRE) || (state == atbs_pkg::ST_ARMED) ||
               (state == atbs_pkg::ST_POST);
  assign trigger_enable_req = (state == atbs_pkg::ST_ARMED);
  assign acq_done           = (state == atbs_pkg::ST_DONE);

  always_ff @(posedge clk) begin
    if (rst || start_cmd) begin
      pre_cnt <= '0;
    end else if (state == atbs_pkg::ST_PRE && pre_cnt < pre_len && div_bus.tick) begin
      pre_cnt <= pre_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || start_cmd) begin
      post_cnt <= '0;
    end else if (ev_trig) begin
      post_cnt <= post_len;
    end else if (state == atbs_pkg::ST_POST && post_cnt != '0 && div_bus.tick) begin
      post_cnt <= post_cnt - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clamp to rate ceiling
  assign eff_mult = (pll_mult > atbs_pkg::MULT_W'(MAX_MULT)) ? atbs_pkg::MULT_W'(MAX_MULT) : pll_mult;
  assign pll_mode = (eff_mult != '0);

  always_ff @(posedge clk) begin
    if (rst) begin
      sample_clk_out <= 1'b0;
      pll_ref_clk    <= 1'b0;
      pll_mult_out   <= '0;
    end else begin
      sample_clk_out <= run && !pll_mode && div_bus.phase;
      pll_ref_clk    <= run && pll_mode && div_bus.phase;
      pll_mult_out   <= eff_mult;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // saturate rather than wrap
  assign icnt_inc = (icnt == '1) ? icnt : icnt + 1'b1;

  // The pulse also ends if the clocks stop first, so it can never hang high.
  // stretcher pulse
  always_ff @(posedge clk) begin
    if (rst || start_cmd) begin
      i_state       <= atbs_pkg::IS_IDLE;
      stretch_pulse <= 1'b0;
      icnt          <= '0;
    end else begin
      unique case (i_state)
        atbs_pkg::IS_IDLE: begin
          if (ev_trig) begin
            i_state       <= atbs_pkg::IS_PULSE;
            stretch_pulse <= 1'b1;
            icnt          <= '0;
          end
        end
        atbs_pkg::IS_PULSE: begin
          icnt <= icnt_inc;
          if (div_bus.tick || !run) begin
            stretch_pulse <= 1'b0;
            i_state       <= atbs_pkg::IS_WAIT;
          end
        end
        atbs_pkg::IS_WAIT: begin
          if (stretch_edge) begin
            i_state <= atbs_pkg::IS_IDLE;
          end else begin
            icnt <= icnt_inc;
          end
        end
      endcase
    end
  end

  assign ev_interp = (i_state == atbs_pkg::IS_WAIT) && stretch_edge && !start_cmd;

  always_ff @(posedge clk) begin
    if (rst || start_cmd) begin
      interp_result <= '0;
      interp_valid  <= 1'b0;
    end else if (ev_interp) begin
      interp_result <= icnt;
      interp_valid  <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // A new event wins over a simultaneous write-one-to-clear.
  always_comb begin
    ev_vec = '0;
    ev_vec[atbs_pkg::INT_DONE_BIT]   = ev_done;
    ev_vec[atbs_pkg::INT_TRIG_BIT]   = ev_trig;
    ev_vec[atbs_pkg::INT_INTERP_BIT] = ev_interp;
  end

  assign w1c = (reg_wr && reg_addr == atbs_pkg::OFF_INT_STATUS) ? reg_wdata[atbs_pkg::INT_W-1:0] : '0;

  always_ff @(posedge clk) begin
    if (rst) begin
      int_status <= '0;
    end else begin
      int_status <= (int_status & ~w1c) | ev_vec;
    end
  end

  assign irq = |(int_status & int_mask);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= '0;
      if (reg_rd) begin
        unique case (reg_addr)
          atbs_pkg::OFF_DIVISOR:    reg_rdata <= 32'(divisor);
          atbs_pkg::OFF_PLL_MULT:   reg_rdata <= 32'(pll_mult);
          atbs_pkg::OFF_PRE_LEN:    reg_rdata <= 32'(pre_len);
          atbs_pkg::OFF_POST_LEN:   reg_rdata <= 32'(post_len);
          atbs_pkg::OFF_STATUS: begin
            reg_rdata[atbs_pkg::ST_RUN_BIT]     <= run;
            reg_rdata[atbs_pkg::ST_ARMED_BIT]   <= trigger_enable_req;
            reg_rdata[atbs_pkg::ST_POST_BIT]    <= (state == atbs_pkg::ST_POST);
            reg_rdata[atbs_pkg::ST_DONE_BIT]    <= acq_done;
            reg_rdata[atbs_pkg::ST_STRETCH_BIT] <= (i_state != atbs_pkg::IS_IDLE);
            reg_rdata[atbs_pkg::ST_IVALID_BIT]  <= interp_valid;
            reg_rdata[atbs_pkg::ST_PLL_BIT]     <= pll_mode;
          end
          atbs_pkg::OFF_INT_STATUS: reg_rdata <= 32'(int_status);
          atbs_pkg::OFF_INT_MASK:   reg_rdata <= 32'(int_mask);
          atbs_pkg::OFF_INTERP:     reg_rdata <= 32'(interp_result);
          atbs_pkg::OFF_CAPS:       reg_rdata <= 32'(MAX_RATE_MSPS);
          default: begin
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_arm;
    @(posedge clk) disable iff (rst)
    (state == atbs_pkg::ST_PRE && pre_cnt >= pre_len && !ctrl_wr) |=> trigger_enable_req;
  endproperty
  a_arm: assert property (p_arm) else $error("Request not raised after pre-trigger count.");

  property p_arm_hold;
    @(posedge clk) disable iff (rst)
    (trigger_enable_req && !trig_edge && !ctrl_wr) |=> trigger_enable_req;
  endproperty
  a_arm_hold: assert property (p_arm_hold) else $error("Request dropped without a trigger.");

  property p_post_load;
    @(posedge clk) disable iff (rst)
    ev_trig |=> (state == atbs_pkg::ST_POST && post_cnt == $past(post_len) && !trigger_enable_req);
  endproperty
  a_post_load: assert property (p_post_load) else $error("Trigger did not load post count.");

  property p_post_dec;
    @(posedge clk) disable iff (rst)
    (state == atbs_pkg::ST_POST && post_cnt != '0 && div_bus.tick && !ctrl_wr) |=> post_cnt == $past(post_cnt) - 1'b1;
  endproperty
  a_post_dec: assert property (p_post_dec) else $error("Post count did not step on a tick.");

  property p_done_stop;
    @(posedge clk) disable iff (rst)
    ev_done |=> acq_done ##1 (!sample_clk_out && !pll_ref_clk);
  endproperty
  a_done_stop: assert property (p_done_stop) else $error("Clocks not stopped at completion.");

  property p_pulse;
    @(posedge clk) disable iff (rst)
    ev_trig |=> stretch_pulse;
  endproperty
  a_pulse: assert property (p_pulse) else $error("No stretcher pulse after trigger.");

  property p_interp_store;
    @(posedge clk) disable iff (rst)
    ev_interp |=> (interp_result == $past(icnt) && interp_valid && i_state == atbs_pkg::IS_IDLE);
  endproperty
  a_interp_store: assert property (p_interp_store) else $error("Interpolation count not stored.");

  property p_start_clear;
    @(posedge clk) disable iff (rst)
    start_cmd |=> (state == atbs_pkg::ST_PRE && pre_cnt == '0 && post_cnt == '0 && icnt == '0 && !acq_done);
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("Start did not clear the sequence.");

  property p_pll_route;
    @(posedge clk) disable iff (rst)
    pll_mode |=> !sample_clk_out;
  endproperty
  a_pll_route: assert property (p_pll_route) else $error("Direct clock active in loop mode.");

  property p_rate_cap;
    @(posedge clk) disable iff (rst)
    pll_mult_out <= atbs_pkg::MULT_W'(MAX_MULT);
  endproperty
  a_rate_cap: assert property (p_rate_cap) else $error("Multiplier above rate ceiling.");

endmodule
`default_nettype wire

// ---- tb/atbs_far_end.sv ----
`timescale 1ns/1ps
`default_nettype none
module atbs_far_end #(
  parameter int TRIG_DLY = 5,
  parameter int STRETCH  = 20
) (
  input  wire logic clk,                      // Reference clock.
  input  wire logic rst,                      // Synchronous reset.
  input  wire logic trigger_enable_req,       // Ready request from the time base.
  input  wire logic stretch_pulse,            // Interval pulse from the time base.
  input  wire logic rogue,                    // Forces a trigger regardless of readiness.
  output logic      qualified_trigger_event,  // Trigger answer.
  output logic      stretch_done              // Stretch finished.
);
  logic [7:0]  tcnt;
  logic [15:0] wid;
  logic [15:0] scnt;

  ////////////////////////////////////////////////////////////////////////////
  // qualified trigger answer
  // TRIG_DLY stands in for the edge selection and the delay timers of the trigger logic.
  // The line is held for a few cycles so the two-stage sync of the time base sees it.
  always_ff @(posedge clk) begin
    if (rst) begin
      tcnt                    <= 8'h00;
      qualified_trigger_event <= 1'b0;
    end else if (rogue) begin
      qualified_trigger_event <= 1'b1;
    end else if (trigger_enable_req && tcnt < 8'(TRIG_DLY)) begin
      tcnt <= tcnt + 8'h01;
    end else if (trigger_enable_req) begin
      qualified_trigger_event <= 1'b1;
    end else begin
      tcnt                    <= 8'h00;
      qualified_trigger_event <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stretched interval
  // The measured width is scaled by STRETCH; a shorter factor keeps the run brief.
  always_ff @(posedge clk) begin
    if (rst) begin
      wid          <= 16'h0000;
      scnt         <= 16'h0000;
      stretch_done <= 1'b0;
    end else if (stretch_pulse) begin
      wid          <= wid + 16'h0001;
      scnt         <= 16'h0000;
      stretch_done <= 1'b0;
    end else if (wid != 16'h0000) begin
      scnt         <= scnt + 16'h0001;
      stretch_done <= (32'(scnt) >= 32'(wid) * STRETCH);
      if (32'(scnt) == 32'(wid) * STRETCH + 4) begin
        wid          <= 16'h0000;
        stretch_done <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct {logic [7:0] a; logic [31:0] d; logic w; logic [31:0] e;} atbs_row_t;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        rogue = 1'b0;
  logic [31:0] reg_rdata, d;
  logic        qte, sdone, trigger_enable_req, stretch_pulse, sample_clk_out, pll_ref_clk, acq_done, irq;
  logic [4:0]  pll_mult_out;
  int          err_total = 0;
  int          cmp_count = 0;
  int          cyc, stog, ptog, n;
  atbs_row_t   rows[14] = '{
    '{8'h04, 32'h0, 1'b0, 32'h0}, '{8'h0C, 32'h0, 1'b0, 32'h0}, '{8'h10, 32'h0, 1'b0, 32'h0},
    '{8'h08, 32'h0, 1'b0, 32'h0}, '{8'h1C, 32'h0, 1'b0, 32'h0}, '{8'h14, 32'h0, 1'b0, 32'h0},
    '{8'h20, 32'h0, 1'b0, 32'h0}, '{8'h24, 32'h0, 1'b0, 32'h7D0}, '{8'h30, 32'h0, 1'b0, 32'h0},
    '{8'h14, 32'hFF, 1'b1, 32'h0}, '{8'h24, 32'h5, 1'b1, 32'h7D0}, '{8'h04, 32'h1, 1'b1, 32'h1},
    '{8'h0C, 32'h3, 1'b1, 32'h3}, '{8'h10, 32'h4, 1'b1, 32'h4}};

  always #5 clk = ~clk;

  atbs_top atbs_top_i (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .qualified_trigger_event(qte), .stretch_done(sdone),
    .trigger_enable_req(trigger_enable_req), .stretch_pulse(stretch_pulse), .sample_clk_out(sample_clk_out),
    .pll_ref_clk(pll_ref_clk), .pll_mult_out(pll_mult_out), .acq_done(acq_done), .irq(irq));
  atbs_far_end atbs_far_end_i (.clk(clk), .rst(rst), .trigger_enable_req(trigger_enable_req),
    .stretch_pulse(stretch_pulse), .rogue(rogue), .qualified_trigger_event(qte), .stretch_done(sdone));

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin err_total++; $display("Error %s expected %h seen %h", nm, e, g); end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin err_total++; $display("Error %s expected %b seen %b", nm, e, g); end
  endtask
  // Waits for the request, then its fall, then completion, noting clock activity on the way.
  task automatic run_acq();
    cyc = 0; stog = 0; ptog = 0; n = 0;
    while (trigger_enable_req !== 1'b1 && n < 400) begin @(posedge clk); n++; end
    while (trigger_enable_req === 1'b1 && n < 800) begin @(posedge clk); n++; end
    chk1("stretch_pulse", 1'b1, stretch_pulse);
    while (acq_done !== 1'b1 && cyc < 400) begin
      @(posedge clk); cyc++; stog += int'(sample_clk_out === 1'b1); ptog += int'(pll_ref_clk === 1'b1);
    end
  endtask
  task automatic test_done();
    $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    test_done();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].a, d);
      chk32("reg", rows[i].e, d);
    end
    $display("register table done");
    wr(8'h00, 32'h1);
    n = 0;
    while (trigger_enable_req !== 1'b1 && n < 100) begin @(posedge clk); n++; end
    rd(8'h14, d);
    chk32("armed", 32'h3, d & 32'h3);
    run_acq();
    chk1("post_span", 1'b1, cyc >= 8 && cyc <= 12);
    chk1("clk_active", 1'b1, stog > 0);
    repeat (4) @(posedge clk);
    chk1("clk_stop", 1'b0, sample_clk_out);
    chk1("irq_masked", 1'b0, irq);
    n = 0; d = 32'h0;
    while (d[5] !== 1'b1 && n < 100) begin rd(8'h14, d); n++; end
    rd(8'h20, d);
    chk1("interp", 1'b1, d >= 32'd20 && d <= 32'd100);
    rd(8'h18, d);
    chk32("int_status", 32'h7, d);
    wr(8'h1C, 32'h7);
    @(posedge clk);
    chk1("irq_on", 1'b1, irq);
    wr(8'h18, 32'h7);
    rd(8'h18, d);
    chk32("int_clear", 32'h0, d);
    chk1("irq_off", 1'b0, irq);
    $display("plain acquisition done");
    wr(8'h08, 32'h1F);
    repeat (2) @(posedge clk);
    chk32("mult_clamp", 32'd20, 32'(pll_mult_out));
    wr(8'h08, 32'h4);
    wr(8'h0C, 32'd40);
    wr(8'h00, 32'h1);
    @(posedge clk);
    chk1("done_clear", 1'b0, acq_done);
    chk32("mult", 32'h4, 32'(pll_mult_out));
    repeat (8) @(posedge clk);
    rogue <= 1'b1;
    repeat (5) @(posedge clk);
    rogue <= 1'b0;
    repeat (10) @(posedge clk);
    rd(8'h14, d);
    chk32("early_trig", 32'h1, d & 32'hF);
    run_acq();
    chk1("post_span2", 1'b1, cyc >= 8 && cyc <= 12);
    chk1("pll_active", 1'b1, ptog > 0 && stog == 0);
    $display("early trigger and loop clock done");
    wr(8'h00, 32'h1);
    wr(8'h00, 32'h2);
    rd(8'h14, d);
    chk32("abort", 32'h0, d & 32'hF);
    chk1("abort_clk", 1'b0, pll_ref_clk);
    $display("abort done");
    test_done();
  end
endmodule
`default_nettype wire
